//--- rtl/eeprom_spi_pkg.sv
// Shared constants and types for the serial EEPROM front end
package eeprom_spi_pkg;

  // Opcode layout: upper nibble must be zero, bit 3 is don't-care
  localparam logic [3:0] OP_PREFIX = 4'h0;
  localparam logic [2:0] OP_SET_LATCH = 3'h6;
  localparam logic [2:0] OP_CLEAR_LATCH = 3'h4;
  localparam logic [2:0] OP_STATUS_READ = 3'h5;
  localparam logic [2:0] OP_STATUS_WRITE = 3'h1;
  localparam logic [2:0] OP_ARRAY_READ = 3'h3;
  localparam logic [2:0] OP_ARRAY_WRITE = 3'h2;

  // Status register field positions
  localparam int ST_PROTECT_EN = 7;
  localparam int ST_RSV_HI = 6;
  localparam int ST_RSV_LO = 4;
  localparam int ST_BP_HI = 3;
  localparam int ST_BP_LO = 2;
  localparam int ST_WEL = 1;
  localparam int ST_READY_BUSY = 0;

  // Values after reset: volatile bits at power-up, nonvolatile as shipped
  localparam logic LATCH_RESET = 1'h0;
  localparam logic PROTECT_EN_RESET = 1'h0;
  localparam logic [1:0] BLOCK_PROTECT_RESET = 2'h0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] RSV_BUSY = 3'h7;
  localparam logic [2:0] RSV_IDLE = 3'h0;
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;

  // Self-timed write cycle, longest time rounds down
  localparam int CLK_HZ = 50_000_000;
  localparam int WRITE_CYCLE_MS = 5;
  localparam int WRITE_CYCLE_CYC = (CLK_HZ / 1000) * WRITE_CYCLE_MS;
  localparam int TIMER_W = 18;

  // Serial link phase
  typedef enum {
    LK_OPCODE,
    LK_STATUS_OUT,
    LK_STATUS_IN,
    LK_ARRAY,
    LK_IGNORE
  } link_state_e;

  // Commands handed from the link to the system domain
  typedef enum logic [1:0] {
    CMD_SET_LATCH,
    CMD_CLEAR_LATCH,
    CMD_STATUS_WRITE,
    CMD_NONE
  } cmd_kind_e;

endpackage

//--- rtl/level_sync.sv
// Two-flop synchroniser for a group of slowly changing levels
`timescale 1ns/10ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [WIDTH-1:0] d, // Level from the other domain
  output logic [WIDTH-1:0] q // Synchronised level
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // level_sync

//--- rtl/write_cycle_timer.sv
// Down-counter that times the self-timed nonvolatile write cycle
`timescale 1ns/10ps
module write_cycle_timer #(
  parameter int CYCLES = eeprom_spi_pkg::WRITE_CYCLE_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic start, // One-cycle pulse that opens the cycle
  output logic busy, // High while the cycle runs
  output logic done // One-cycle pulse at the end of the cycle
);

  logic [eeprom_spi_pkg::TIMER_W-1:0] remain;

  // Count down; a start while busy is ignored so the cycle always completes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      remain <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!busy && start)
      begin
        remain <= eeprom_spi_pkg::TIMER_W'(CYCLES - 1);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (remain == '0)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          remain <= remain - 1'b1;
        end
      end
    end
  end

endmodule // write_cycle_timer

//--- rtl/eeprom_spi_front.sv
// Serial EEPROM slave front end: link shifter, pause, status register control
//
// Contract
// - Chip select toggle without clocks resets interface
// - Power-up clears write latch and busy flag
// - Power-up keeps protect enable and block bits
// - Start deselected, unpaused; activate on select fall
// - Shipped protect enable and block bits zero
// - Modes 0/3: sample rising, drive falling
// - Deselected: ignore input, output floats
// - Input MSB first from first rising edge
// - Output MSB first after the opcode
// - First byte after select is the opcode
// - Invalid opcode: ignore rest, float until reselect
// - Pause never suspends a running write cycle
// - Pause starts in clock-low phase while selected
// - Paused: float output, ignore clock and input
// - Pause ends at a clock-low phase
// - Deselect while paused aborts, clears write latch
// - Protect pin low with enable blocks status writes
// - Protect pin fall before cycle aborts status write
// - Protect enable clear makes protect pin ignored
// - Decode set, clear and status read opcodes
// - Status layout: enable, reserved, blocks, latch, busy
// - Status write alters only bits 7, 3, 2
`timescale 1ns/10ps
module eeprom_spi_front #(
  parameter int WRITE_CYCLES = eeprom_spi_pkg::WRITE_CYCLE_CYC
) (
  input wire logic clk, // System clock, 50 MHz
  input wire logic rst, // Power-up reset, asynchronous, active high
  input wire logic nv_rst, // Factory erase of the nonvolatile bits, active high
  input wire logic sck, // Serial clock from the master
  input wire logic cs_n, // Chip select, active low
  input wire logic si, // Serial data in
  input wire logic hold_n, // Pause pin, active low
  input wire logic wp_n, // Write-protect pin, active low
  output logic so, // Serial data out
  output logic so_oe, // Output enable for so, high while driven
  output logic [7:0] status_byte // Live status register
);

  // ---------------- Link domain (serial clock) ----------------

  logic link_rst;
  eeprom_spi_pkg::link_state_e state;
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [7:0] snap;
  logic [7:0] status_link;
  logic [7:0] rx_byte;
  logic byte_end;
  logic issue_now;
  eeprom_spi_pkg::cmd_kind_e issue_kind;
  logic cmd_toggle;
  eeprom_spi_pkg::cmd_kind_e cmd_kind;
  logic [7:0] cmd_data;

  // Deselect resets the link side except the command mailbox, so a bare select toggle recovers it
  assign link_rst = rst | cs_n;

  // Received byte and byte boundary on the current rising edge
  assign rx_byte = {shift_in, si};
  assign byte_end = (bit_cnt == eeprom_spi_pkg::BIT_CNT_LAST);

  // Status bits seen by the link; clock only runs in frames, and the
  // opcode's eight edges flush this synchroniser before the snapshot
  level_sync #(
    .WIDTH(8)
  ) u_status_sync (
    .clk(sck),
    .rst(link_rst),
    .d(status_byte),
    .q(status_link)
  );

  // Opcode decode and commands that the system domain must act on
  always_comb
  begin
    issue_now = 1'b0;
    issue_kind = eeprom_spi_pkg::CMD_NONE;
    if (hold_n && byte_end)
    begin
      if (state == eeprom_spi_pkg::LK_OPCODE && rx_byte[7:4] == eeprom_spi_pkg::OP_PREFIX)
      begin
        if (rx_byte[2:0] == eeprom_spi_pkg::OP_SET_LATCH)
        begin
          issue_now = 1'b1;
          issue_kind = eeprom_spi_pkg::CMD_SET_LATCH;
        end
        else if (rx_byte[2:0] == eeprom_spi_pkg::OP_CLEAR_LATCH)
        begin
          issue_now = 1'b1;
          issue_kind = eeprom_spi_pkg::CMD_CLEAR_LATCH;
        end
      end
      else if (state == eeprom_spi_pkg::LK_STATUS_IN)
      begin
        issue_now = 1'b1;
        issue_kind = eeprom_spi_pkg::CMD_STATUS_WRITE;
      end
    end
  end

  // Sampling on rising edges; pin level at the edge is the end of the
  // low phase, so a pause change during high waits for the next low
  always_ff @(posedge sck or posedge link_rst)
  begin
    if (link_rst)
    begin
      state <= eeprom_spi_pkg::LK_OPCODE;
      bit_cnt <= eeprom_spi_pkg::BIT_CNT_RESET;
      shift_in <= '0;
      snap <= eeprom_spi_pkg::STATUS_RESET;
    end
    else if (hold_n)
    begin
      bit_cnt <= bit_cnt + 1'b1;
      shift_in <= rx_byte[6:0];
      case (state)
        eeprom_spi_pkg::LK_OPCODE:
        begin
          if (byte_end)
          begin
            if (rx_byte[7:4] != eeprom_spi_pkg::OP_PREFIX)
            begin
              state <= eeprom_spi_pkg::LK_IGNORE;
            end
            else
            begin
              case (rx_byte[2:0])
                eeprom_spi_pkg::OP_STATUS_READ:
                begin
                  state <= eeprom_spi_pkg::LK_STATUS_OUT;
                  snap <= status_link;
                end
                eeprom_spi_pkg::OP_STATUS_WRITE: state <= eeprom_spi_pkg::LK_STATUS_IN;
                eeprom_spi_pkg::OP_ARRAY_READ: state <= eeprom_spi_pkg::LK_ARRAY;
                eeprom_spi_pkg::OP_ARRAY_WRITE: state <= eeprom_spi_pkg::LK_ARRAY;
                default: state <= eeprom_spi_pkg::LK_IGNORE;
              endcase
            end
          end
        end
        eeprom_spi_pkg::LK_STATUS_OUT:
        begin
          // Repeat the status byte for as long as the master clocks
          if (byte_end)
          begin
            snap <= status_link;
          end
        end
        eeprom_spi_pkg::LK_STATUS_IN:
        begin
          if (byte_end)
          begin
            state <= eeprom_spi_pkg::LK_IGNORE;
          end
        end
        eeprom_spi_pkg::LK_ARRAY: state <= eeprom_spi_pkg::LK_ARRAY;
        eeprom_spi_pkg::LK_IGNORE: state <= eeprom_spi_pkg::LK_IGNORE;
        default: state <= eeprom_spi_pkg::LK_IGNORE;
      endcase
    end
  end

  // Output changes on falling edges; the level of the pause pin at the
  // start of each low phase decides whether the pin floats
  always_ff @(negedge sck or posedge link_rst)
  begin
    if (link_rst)
    begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end
    else
    begin
      so <= snap[~bit_cnt];
      so_oe <= (state == eeprom_spi_pkg::LK_STATUS_OUT) && hold_n;
    end
  end

  // Command mailbox survives deselect: fields settle before the toggle
  always_ff @(posedge sck or posedge rst)
  begin
    if (rst)
    begin
      cmd_toggle <= 1'b0;
      cmd_kind <= eeprom_spi_pkg::CMD_NONE;
      cmd_data <= eeprom_spi_pkg::STATUS_RESET;
    end
    else if (!cs_n && issue_now)
    begin
      cmd_toggle <= ~cmd_toggle;
      cmd_kind <= issue_kind;
      cmd_data <= rx_byte;
    end
  end

  // ---------------- System domain ----------------

  logic cs_s;
  logic hold_s;
  logic wp_s;
  logic tog_s;
  logic cs_prev;
  logic tog_prev;
  logic cs_rise;
  logic tog_evt;
  logic pend;
  eeprom_spi_pkg::cmd_kind_e pend_kind;
  logic [7:0] pend_data;
  logic wp_abort;
  logic protect_block;
  logic write_latch;
  logic protect_en;
  logic [1:0] block_protect;
  logic [2:0] staged;
  logic start_write;
  logic busy;
  logic done;

  // Pins and the command toggle cross by two flops
  level_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d({cs_n, hold_n, wp_n, cmd_toggle}),
    .q({cs_s, hold_s, wp_s, tog_s})
  );

  // Edge history for deselect and command arrival
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cs_prev <= 1'b1;
      tog_prev <= 1'b0;
    end
    else
    begin
      cs_prev <= cs_s;
      tog_prev <= tog_s;
    end
  end

  assign cs_rise = cs_s && !cs_prev;
  assign tog_evt = tog_s ^ tog_prev;
  assign protect_block = protect_en && !wp_s;

  // Pending command, acted on at deselect like the real part
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend <= 1'b0;
      pend_kind <= eeprom_spi_pkg::CMD_NONE;
      pend_data <= eeprom_spi_pkg::STATUS_RESET;
    end
    else if (tog_evt)
    begin
      pend <= 1'b1;
      pend_kind <= cmd_kind;
      pend_data <= cmd_data;
    end
    else if (cs_rise)
    begin
      pend <= 1'b0;
    end
  end

  // Protect pin falling while still selected kills a pending status write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_abort <= 1'b0;
    end
    else if (cs_rise)
    begin
      wp_abort <= 1'b0;
    end
    else if (!cs_s && pend && pend_kind == eeprom_spi_pkg::CMD_STATUS_WRITE && protect_block)
    begin
      wp_abort <= 1'b1;
    end
  end

  // Start only a fresh write; a running cycle ignores the protect pin
  assign start_write = cs_rise && hold_s && pend && !busy && write_latch && !protect_block
    && !wp_abort && pend_kind == eeprom_spi_pkg::CMD_STATUS_WRITE;

  // Write enable latch: volatile, cleared at power-up, by pause abort,
  // and at the end of a write cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      write_latch <= eeprom_spi_pkg::LATCH_RESET;
    end
    else if (cs_rise && !hold_s)
    begin
      write_latch <= 1'b0;
    end
    else if (done)
    begin
      write_latch <= 1'b0;
    end
    else if (cs_rise && pend && !busy)
    begin
      if (pend_kind == eeprom_spi_pkg::CMD_SET_LATCH)
      begin
        write_latch <= 1'b1;
      end
      else if (pend_kind == eeprom_spi_pkg::CMD_CLEAR_LATCH)
      begin
        write_latch <= 1'b0;
      end
    end
  end

  // Value to commit, held for the whole cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      staged <= '0;
    end
    else if (start_write)
    begin
      staged <= {pend_data[eeprom_spi_pkg::ST_PROTECT_EN],
                 pend_data[eeprom_spi_pkg::ST_BP_HI:eeprom_spi_pkg::ST_BP_LO]};
    end
  end

  // Self-timed cycle; pause and deselect do not reach it
  write_cycle_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .start(start_write),
    .busy(busy),
    .done(done)
  );

  // Nonvolatile bits: untouched by power-up reset, only by factory erase
  always_ff @(posedge clk or posedge nv_rst)
  begin
    if (nv_rst)
    begin
      protect_en <= eeprom_spi_pkg::PROTECT_EN_RESET;
      block_protect <= eeprom_spi_pkg::BLOCK_PROTECT_RESET;
    end
    else if (done)
    begin
      protect_en <= staged[2];
      block_protect <= staged[1:0];
    end
  end

  // Status image; reserved bits read ones during a write cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_byte <= eeprom_spi_pkg::STATUS_RESET;
    end
    else
    begin
      status_byte[eeprom_spi_pkg::ST_PROTECT_EN] <= protect_en;
      status_byte[eeprom_spi_pkg::ST_RSV_HI:eeprom_spi_pkg::ST_RSV_LO] <=
        busy ? eeprom_spi_pkg::RSV_BUSY : eeprom_spi_pkg::RSV_IDLE;
      status_byte[eeprom_spi_pkg::ST_BP_HI:eeprom_spi_pkg::ST_BP_LO] <= block_protect;
      status_byte[eeprom_spi_pkg::ST_WEL] <= write_latch;
      status_byte[eeprom_spi_pkg::ST_READY_BUSY] <= busy;
    end
  end

endmodule // eeprom_spi_front

//--- tb/eeprom_spi_front_assertions.sv
// Concurrent checks on the ports of the serial EEPROM front end
`timescale 1ns/10ps
module eeprom_spi_front_checker #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic clk, // System clock
  input wire logic rst, // Power-up reset
  input wire logic nv_rst, // Factory erase
  input wire logic sck, // Serial clock
  input wire logic cs_n, // Chip select, active low
  input wire logic si, // Serial data in
  input wire logic hold_n, // Pause pin, active low
  input wire logic wp_n, // Write-protect pin, active low
  input wire logic so, // Serial data out
  input wire logic so_oe, // Output enable for so
  input wire logic [7:0] status_byte // Live status register
);
  int bcnt;

  // Length of the busy span, so the write cycle time can be judged
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bcnt <= 0;
    else if (status_byte[0])
      bcnt <= bcnt + 1;
    else
      bcnt <= 0;
  end

  AST_DESELECT_FLOAT: assert property (@(posedge clk) disable iff (rst)
    cs_n && $past(cs_n) |-> !so_oe) else $error("output driven while deselected");
  AST_RSV_BUSY: assert property (@(posedge clk) disable iff (rst)
    status_byte[6:4] == {3{status_byte[0]}}) else $error("reserved bits do not follow busy");
  AST_BUSY_SPAN: assert property (@(posedge clk) disable iff (rst)
    $fell(status_byte[0]) |-> bcnt >= WRITE_CYCLES - 2 && bcnt <= WRITE_CYCLES + 2)
    else $error("write cycle length off");
  AST_NV_AT_END: assert property (@(posedge clk) disable iff (rst || nv_rst)
    !$past(rst) && !$past(rst, 2) && !$past(nv_rst) && $changed({status_byte[7], status_byte[3:2]})
    |-> $past(status_byte[0], 2) && !$past(status_byte[0]))
    else $error("protect bits moved outside a write end");
  AST_LATCH_OFF_FRAME: assert property (@(posedge clk) disable iff (rst)
    $rose(status_byte[1]) |-> cs_n && $past(cs_n, 2)) else $error("latch set inside a frame");
  AST_HOLD_FLOAT: assert property (@(negedge sck) disable iff (rst || cs_n)
    !hold_n |=> !so_oe) else $error("output driven while paused");
  AST_SO_STEADY: assert property (@(posedge clk) disable iff (rst)
    sck && $past(sck) && !cs_n && !$past(cs_n) |-> $stable(so)) else $error("so moved, sck high");
  AST_READY_AFTER_RESET: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> status_byte[1:0] == 2'h0) else $error("latch or busy set after reset");

  C_BUSY: cover property (@(posedge clk) $rose(status_byte[0]));
  C_READ: cover property (@(negedge sck) $rose(so_oe));
  C_PAUSE: cover property (@(posedge clk) !cs_n && !hold_n);
endmodule // eeprom_spi_front_checker

//--- tb/spi_master_model.sv
// Behavioural SPI master that drives the serial side of the front end
`timescale 1ns/10ps
module spi_master_model (
  output logic sck, // Serial clock, runs only inside frames
  output logic cs_n, // Chip select, active low
  output logic si, // Serial data to the device
  output logic hold_n, // Pause pin, active low
  input wire logic so, // Serial data from the device
  input wire logic so_oe // Device drives so
);
  logic idle; // Clock idle level, high selects mode 3
  logic oe_seen; // Output enable seen during the frame

  // Idle levels before the first frame
  initial
  begin
    idle = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    oe_seen = 1'b0;
  end

  // Idle level is settled before select falls and kept after it rises
  task automatic start(input logic mode);
    idle = mode;
    sck = mode;
    #40 cs_n = 1'b0;
    oe_seen = 1'b0;
    #40;
  endtask

  // 80 ns bit time; optional pause of two clocks before bit 3
  task automatic shift(input logic [7:0] tx, input int n, input bit pz, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sck = 1'b0;
      if (pz && i == 3)
      begin
        hold_n = 1'b0;
        repeat (2)
        begin
          si = ~si;
          #40 sck = 1'b1;
          #40 sck = 1'b0;
        end
        hold_n = 1'b1;
      end
      si = tx[i];
      #40 sck = 1'b1;
      rx[i] = so;
      if (so_oe === 1'b1)
        oe_seen = 1'b1;
      #40;
    end
  endtask

  // Released data line shows the inverse, not a stale bit
  task automatic stop(input bit held);
    sck = idle;
    if (held)
      hold_n = 1'b0;
    #80 cs_n = 1'b1;
    si = ~si;
    #40 hold_n = 1'b1;
    #200;
  endtask
endmodule // spi_master_model

//--- tb/tb_eeprom_spi_front.sv
// Self-checking bench for the serial EEPROM front end
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module tb_eeprom_spi_front;
  logic clk, rst, nv_rst, wp_n, sck, cs_n, si, hold_n, so, so_oe;
  logic [7:0] status_byte, rx;
  logic [7:0] bad [3] = '{8'h07, 8'h10, 8'h00};
  int err_count = 0;
  int samples_checked = 0;

  eeprom_spi_front #(.WRITE_CYCLES(20)) i_dut (.clk(clk), .rst(rst), .nv_rst(nv_rst),
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .status_byte(status_byte));
  spi_master_model i_m (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
    .so_oe(so_oe));

  // 50 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_sim;
    $display("checked %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    i_m.start(1'b0);
    i_m.shift(op, 8, 1'b0, rx);
    i_m.stop(1'b0);
  endtask

  // Latch set, then status write; judges busy and the final protect bits
  task automatic wsr(input logic [7:0] d, input bit pz, wf, go, input logic [7:0] e);
    int n;
    cmd(8'h06);
    i_m.start(1'b0);
    i_m.shift(8'h01, 8, 1'b0, rx);
    i_m.shift(d, 8, pz, rx);
    if (wf)
      @(posedge clk) wp_n <= 1'b0;
    i_m.stop(1'b0);
    @(negedge clk);
    `CHK(status_byte[0], go)
    if (go)
      `CHK(status_byte[6:4], 3'h7)
    for (n = 0; n < 40 && status_byte[0] !== 1'b0; n++)
      @(negedge clk);
    @(negedge clk);
    `CHK(status_byte[7:2], e[7:2])
    if (go)
      `CHK(status_byte[1:0], 2'h0)
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    nv_rst = 1'b1;
    wp_n = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    nv_rst <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK(status_byte, 8'h00)
    for (int k = 0; k < 4; k++)
    begin
      cmd(8'h04 | (k[0] ? 8'h00 : 8'h02) | (k[1] ? 8'h08 : 8'h00));
      `CHK(status_byte[1], ~k[0])
    end
    wsr(8'hff, 1'b1, 1'b0, 1'b1, 8'h8c);
    i_m.start(1'b1);
    i_m.shift(8'h05, 8, 1'b0, rx);
    i_m.shift(8'h00, 8, 1'b0, rx);
    i_m.stop(1'b0);
    `CHK(rx, 8'h8c)
    wsr(8'h00, 1'b0, 1'b1, 1'b0, 8'h8c);
    wsr(8'h00, 1'b0, 1'b0, 1'b0, 8'h8c);
    @(posedge clk) wp_n <= 1'b1;
    wsr(8'h00, 1'b0, 1'b0, 1'b1, 8'h00);
    @(posedge clk) wp_n <= 1'b0;
    wsr(8'h0c, 1'b0, 1'b0, 1'b1, 8'h0c);
    foreach (bad[k])
    begin
      i_m.start(1'b0);
      i_m.shift(bad[k], 8, 1'b0, rx);
      i_m.shift(8'h06, 8, 1'b0, rx);
      i_m.shift(8'h05, 8, 1'b0, rx);
      i_m.stop(1'b0);
      `CHK(i_m.oe_seen, 1'b0)
      `CHK(status_byte[1], 1'b0)
    end
    i_m.start(1'b0);
    i_m.shift(8'h00, 5, 1'b0, rx);
    i_m.stop(1'b0);
    i_m.start(1'b0);
    i_m.stop(1'b0);
    cmd(8'h06);
    `CHK(status_byte[1], 1'b1)
    i_m.start(1'b0);
    i_m.shift(8'h05, 8, 1'b0, rx);
    i_m.stop(1'b1);
    `CHK(status_byte[1], 1'b0)
    cmd(8'h06);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK(status_byte, 8'h0c)
    end_sim();
  end

  // Watchdog well beyond the roughly 32 us the sequence needs
  initial
  begin
    #500000;
    err_count++;
    end_sim();
  end
endmodule // tb_eeprom_spi_front

bind eeprom_spi_front eeprom_spi_front_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (
  .clk(clk), .rst(rst), .nv_rst(nv_rst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
  .wp_n(wp_n), .so(so), .so_oe(so_oe), .status_byte(status_byte));
